// ### hw/expiry_timer_defines.svh
// timing counts and reset values for the expiry timer
`ifndef EXPIRY_TIMER_DEFINES_SVH
`define EXPIRY_TIMER_DEFINES_SVH
`define CLK_PERIOD_PS 5000
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS * 1000 / `CLK_PERIOD_PS)
`define TIMEOUT_DEFAULT_US 2000
`define TIMEOUT_DEFAULT_TICKS 20'h007D0
`define TIMEOUT_W 20
`define TICK_DIV_W 8
`endif

// ### hw/expiry_timer_pkg.sv
// types for the expiry timer
package expiry_timer_pkg;
  typedef logic [19:0] timeout_t;
  typedef enum logic [1:0] {
    ST_FROZEN = 2'b00,
    ST_COUNT = 2'b01,
    ST_FIRE = 2'b10
  } timer_state_e;
endpackage : expiry_timer_pkg

// ### hw/tick_if.sv
// carrier for the tick strobe between divider and timer core
`timescale 1ns/1ps
interface tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface : tick_if

// ### hw/tick_divider.sv
// divider that makes the one-cycle counting tick
`timescale 1ns/1ps
`include "expiry_timer_defines.svh"
module tick_divider
  import expiry_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  tick_if.src tk
);
  localparam int DIV_W = `TICK_DIV_W;
  localparam logic [`TICK_DIV_W-1:0] DIV_LAST = DIV_W'(`TICK_CYCLES - 1);
  logic [`TICK_DIV_W-1:0] div_reg;
  logic [`TICK_DIV_W-1:0] div_next;
  wire wrap = (div_reg == DIV_LAST);

  // divider restarts whenever counting is halted, so ticks stay aligned
  assign div_next = (!tk.run || wrap) ? '0 : div_reg + 1'b1;
  assign tk.tick = tk.run && wrap;

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule : tick_divider

// ### hw/expiry_timer.sv
// expiry timer core: enable, programmable timeout, warm reset on expiry
// Functional notes
// R1: reset loads the default timeout of 2 ms.
// R2: after reset the timer is disabled and does not count.
// R3: counting starts only after software writes the enable.
// R4: once enabled the counter advances toward the current timeout.
// R5: a timeout write while running takes effect on the running count.
// R6: at timeout, issue warm reset to system and drive reset output.
// R7: after its own warm reset the timer restarts, staying enabled.
// R8: every warm reset restores the 2 ms timeout.
// R9: power-on reset freezes the timer until enabled again.
// R10: counter advances on a fixed 1 us tick; timeout counts ticks.
`timescale 1ns/1ps
`include "expiry_timer_defines.svh"
module expiry_timer
  import expiry_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic por_in,
  input wire logic enable_wr,
  input wire logic timeout_wr,
  input wire timeout_t timeout_wdata,
  output logic warm_rst,
  output logic rst_out,
  output logic running,
  output timeout_t count,
  output timeout_t timeout
);

  // default timeout in ticks, restored by srst, por and every expiry
  localparam timeout_t TMO_DEFAULT = `TIMEOUT_DEFAULT_TICKS;
  // smallest legal timeout; a zero write is stored as one tick instead
  localparam timeout_t TMO_MIN = 20'h00001;
  // one step of the tick counter
  localparam timeout_t CNT_STEP = 20'h00001;

  // sequencer state
  timer_state_e state_reg;
  timer_state_e state_next;

  // tick count since enable or since the last expiry
  timeout_t cnt_reg;
  timeout_t cnt_next;

  // live timeout, in ticks
  timeout_t tmo_reg;
  timeout_t tmo_next;

  // power-on reset synchroniser
  logic por_s1_reg;
  logic por_s2_reg;

  // registered expiry pulse that feeds both reset outputs
  logic fire_reg;
  logic fire_next;

  // decoded state
  logic st_frozen;
  logic st_count;
  logic st_fire;

  // decoded sequencing events
  logic por_hold;
  logic enable_take;
  logic tick_seen;
  logic expire;

  // decoded timeout events
  logic tmo_take;
  logic tmo_restore;
  timeout_t wdata_legal;

  // decoded counter events
  logic cnt_clear;
  logic cnt_step;
  timeout_t cnt_inc;

  // tick strobe carrier between the divider and this core
  tick_if tk ();

  // fixed 1 us tick; the divider sits at zero while not counting
  tick_divider tick_divider_inst (
    .mclk(mclk),
    .srst(srst),
    .tk(tk)
  );

  // por pin is asynchronous to mclk: first synchroniser stage
  always_ff @(posedge mclk) begin
    if (srst) begin
      por_s1_reg <= 1'b0;
    end else begin
      por_s1_reg <= por_in;
    end
  end

  // second stage; only this flop reads the first one
  always_ff @(posedge mclk) begin
    if (srst) begin
      por_s2_reg <= 1'b0;
    end else begin
      por_s2_reg <= por_s1_reg;
    end
  end

  // state decode
  assign st_frozen = (state_reg == ST_FROZEN);
  assign st_count = (state_reg == ST_COUNT);
  assign st_fire = (state_reg == ST_FIRE);

  // divider runs only while counting, so every count starts tick-aligned
  assign tk.run = st_count; // R10
  assign tick_seen = tk.tick;

  // synchronised por outranks every software strobe
  assign por_hold = por_s2_reg; // R9
  // an enable while already running has nothing left to do
  assign enable_take = st_frozen && enable_wr && !por_hold; // R3

  // cannot wrap: the count stops at the timeout, at most all ones
  assign cnt_inc = cnt_reg + CNT_STEP;
  // compared against the live timeout; a value lowered below the count
  // expires on the next tick rather than at once
  assign expire = st_count && tick_seen && (cnt_inc >= tmo_reg); // R6

  // next state; por freezes the timer from any state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_FROZEN: begin
        if (enable_take) begin
          state_next = ST_COUNT; // R3 R4
        end else begin
          state_next = ST_FROZEN; // R2
        end
      end
      ST_COUNT: begin
        if (expire) begin
          state_next = ST_FIRE; // R6
        end else begin
          state_next = ST_COUNT; // R4
        end
      end
      ST_FIRE: begin
        state_next = ST_COUNT; // R7
      end
      default: begin
        state_next = ST_FROZEN;
      end
    endcase
    if (por_hold) begin
      state_next = ST_FROZEN; // R9
    end
  end

  // counter: held at zero unless counting, steps once per tick
  assign cnt_clear = !st_count || por_hold; // R2 R9
  assign cnt_step = st_count && tick_seen; // R4 R10
  assign cnt_next = cnt_clear ? '0 :
                    (cnt_step ? cnt_inc : cnt_reg);

  // timeout: warm reset and por restore the default
  assign tmo_restore = por_hold || st_fire; // R8
  // a write in the expiry cycle is lost so the default always wins there
  assign tmo_take = timeout_wr && !tmo_restore; // R5
  assign wdata_legal = (timeout_wdata == '0) ? TMO_MIN :
                       timeout_wdata;
  assign tmo_next = tmo_restore ? TMO_DEFAULT :
                    (tmo_take ? wdata_legal : tmo_reg);

  // the expiry pulse lasts exactly the fire cycle
  assign fire_next = (state_next == ST_FIRE); // R6

  // sequencer state; reset leaves the timer disabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_FROZEN; // R2
    end else begin
      state_reg <= state_next;
    end
  end

  // tick counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // live timeout; reset loads the 2 ms default
  always_ff @(posedge mclk) begin
    if (srst) begin
      tmo_reg <= TMO_DEFAULT; // R1
    end else begin
      tmo_reg <= tmo_next;
    end
  end

  // expiry pulse flop, so the reset outputs carry no decode glitches
  always_ff @(posedge mclk) begin
    if (srst) begin
      fire_reg <= 1'b0;
    end else begin
      fire_reg <= fire_next;
    end
  end

  // reset outputs: one-cycle pulse on expiry
  assign warm_rst = fire_reg; // R6
  assign rst_out = fire_reg; // R6

  // status outputs: count and timeout straight from the flops, running decoded from the state
  assign running = !st_frozen;
  assign count = cnt_reg;
  assign timeout = tmo_reg;
endmodule : expiry_timer

// ### tb/expiry_timer_asserts.sv
// concurrent checks on the expiry timer's ports
`timescale 1ns/1ps
`include "expiry_timer_defines.svh"
module expiry_timer_asserts
  import expiry_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic por_in,
  input wire logic enable_wr,
  input wire logic timeout_wr,
  input wire timeout_t timeout_wdata,
  input wire logic warm_rst,
  input wire logic rst_out,
  input wire logic running,
  input wire timeout_t count,
  input wire timeout_t timeout
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_off; !running && !enable_wr |=> !running; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_on; enable_wr && !$past(por_in) && !$past(por_in, 2)
    |=> running; endproperty
  a_on: assert property (p_on) else $error("on");
  property p_def; warm_rst && !$past(por_in, 2) |=>
    timeout == `TIMEOUT_DEFAULT_TICKS && running; endproperty
  a_def: assert property (p_def) else $error("def");
  property p_out; warm_rst |-> rst_out && $past(running); endproperty
  a_out: assert property (p_out) else $error("out");
  property p_one; warm_rst |=> !warm_rst && !rst_out; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_frz; !running ##1 !running |-> $stable(count); endproperty
  a_frz: assert property (p_frz) else $error("frz");
  property p_tk; $changed(count) |=> ($stable(count) || count == 0)[*8];
  endproperty
  a_tk: assert property (p_tk) else $error("tick");
  property p_por; por_in [*5] |-> !running; endproperty
  a_por: assert property (p_por) else $error("por");
  property p_wr;
    timeout_wr && !warm_rst && !$past(por_in, 2) |=>
      timeout == (($past(timeout_wdata) == '0) ? 20'h00001 :
      $past(timeout_wdata));
  endproperty
  a_wr: assert property (p_wr) else $error("timeout write lost");
endmodule : expiry_timer_asserts
bind expiry_timer expiry_timer_asserts expiry_timer_asserts_inst (
  .mclk(mclk),
  .srst(srst),
  .por_in(por_in),
  .enable_wr(enable_wr),
  .timeout_wr(timeout_wr),
  .timeout_wdata(timeout_wdata),
  .warm_rst(warm_rst),
  .rst_out(rst_out),
  .running(running),
  .count(count),
  .timeout(timeout)
);

// ### tb/tb_expiry_timer.sv
// bench for the expiry timer with a cycle model of its rules
`timescale 1ns/1ps
`include "expiry_timer_defines.svh"
module tb_expiry_timer import expiry_timer_pkg::*;;
  localparam int TICK = `TICK_CYCLES;
  localparam int DEF = `TIMEOUT_DEFAULT_TICKS;
  logic mclk = 0, srst = 1, por_in = 0, enable_wr = 0, timeout_wr = 0;
  logic warm_rst, rst_out, running;
  timeout_t timeout_wdata = '0, count, timeout;
  int error_cnt = 0, checks = 0, n, mt = DEF;
  int m_st = 0, m_cnt = 0, m_tmo = DEF, m_div = 0;
  bit tk_m, ps;
  bit pq[$] = '{0, 0};
  logic [31:0] seed = 32'h8C5F7D72;
  always #2.5 mclk = ~mclk;
  expiry_timer expiry_timer_inst (
    .mclk(mclk), .srst(srst), .por_in(por_in), .enable_wr(enable_wr),
    .timeout_wr(timeout_wr), .timeout_wdata(timeout_wdata),
    .warm_rst(warm_rst), .rst_out(rst_out), .running(running),
    .count(count), .timeout(timeout)
  );
  // cycle model: 0 frozen, 1 counting, 2 firing; por lands two edges late
  always @(posedge mclk) begin
    if (srst) begin
      m_st = 0;
      m_cnt = 0;
      m_tmo = DEF;
      m_div = 0;
      pq = '{0, 0};
    end else begin
      ps = pq.pop_front();
      pq.push_back(por_in);
      tk_m = (m_st == 1) && (m_div == TICK - 1);
      m_div = (m_st == 1 && !tk_m) ? m_div + 1 : 0;
      if (ps || m_st == 2) begin
        m_st = ps ? 0 : 1;
        m_cnt = 0;
        m_tmo = DEF;
      end else begin
        if (m_st == 1 && tk_m) m_cnt++;
        if (m_st == 0 && enable_wr) m_st = 1;
        else if (m_st == 1 && tk_m && m_cnt >= m_tmo) m_st = 2;
        if (timeout_wr) m_tmo = (timeout_wdata == 0) ? 1 : timeout_wdata;
      end
    end
  end
  // every settled output against the model, half a cycle after the edge
  always @(negedge mclk) begin
    if (!srst) begin
      chk(running, m_st != 0);
      chk(warm_rst, m_st == 2);
      chk(rst_out, m_st == 2);
      chk(count, m_cnt);
      chk(timeout, m_tmo);
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ s << 5;
  endfunction : xs
  task automatic chk(logic [31:0] v, e);
    checks++;
    if (v !== e) error_cnt++;
    if (v !== e) $display("BAD %0t mismatch got %0h want %0h", $time, v, e);
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // planned run is about 1600 cycles; this limit is roughly two and a half times that
  initial begin
    #20000 error_cnt++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 0;
    repeat (300) @(posedge mclk);
    #1 chk(timeout, DEF);
    chk(count, 0);
    chk(running, 0);
    $display("reset values done");
    seed = xs(seed);
    mt = 2 + seed % 4;
    @(posedge mclk) enable_wr <= 1;
    @(posedge mclk) enable_wr <= 0;
    timeout_wr <= 1;
    timeout_wdata <= timeout_t'(mt);
    @(posedge mclk) timeout_wr <= 0;
    #1 chk(timeout, mt);
    chk(running, 1);
    for (n = 2; warm_rst !== 1'b1 && n < 2000; n++) @(posedge mclk) #1;
    chk(n / TICK, mt);
    chk(rst_out, 1);
    @(posedge mclk) #1 chk(timeout, DEF);
    chk(warm_rst, 0);
    chk(running, 1);
    $display("expiry done");
    @(posedge mclk) por_in <= 1;
    repeat (300) @(posedge mclk);
    #1 chk(running, 0);
    chk(count, 0);
    $display("freeze done");
    @(posedge mclk) por_in <= 0;
    repeat (3) @(posedge mclk);
    enable_wr <= 1;
    timeout_wr <= 1;
    timeout_wdata <= '0;
    @(posedge mclk) enable_wr <= 0;
    timeout_wr <= 0;
    #1;
    for (n = 1; warm_rst !== 1'b1 && n < 2000; n++) @(posedge mclk) #1;
    chk(n / TICK, 1);
    $display("zero timeout done");
    @(posedge mclk) srst <= 1;
    @(posedge mclk) srst <= 0;
    enable_wr <= 1;
    #1 chk(running, 0);
    chk(timeout, DEF);
    @(posedge mclk) enable_wr <= 0;
    #1 chk(running, 1);
    $display("reset rerun done");
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule : tb_expiry_timer
